/* File: logic/sepwr_mem.sv */
// Simple dual-port byte memory with one write port and a registered read port.
// Assumes both ports are used from a single clock domain.
`timescale 1ns/100ps
module sepwr_mem #(
  parameter int AW = 6,
  parameter int DW = 8
) (
  // Clock.
  input  logic          clk,
  // Write port.
  input  logic          we,
  input  logic [AW-1:0] waddr,
  input  logic [DW-1:0] wdata,
  // Read port.
  input  logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata_r
);

  if (AW < 1 || DW < 1) begin : g_bad_shape
    $error("sepwr_mem needs positive address and data widths");
  end

  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_r <= mem[raddr];
  end

endmodule : sepwr_mem

/* File: logic/sepwr_pkg.sv */
// Constants, state encoding and timing for the two-wire serial EEPROM slave.
// Assumes a 20 MHz reference clock and a free-running link sampling clock.
package sepwr_pkg;

  localparam int          ADDR_W       = 15;
  localparam int          DATA_W       = 8;
  localparam int          PAGE_W       = 6;
  localparam int          PAGE_BYTES   = 64;
  localparam int          CS_W         = 3;
  localparam logic [3:0]  CTRL_CODE    = 4'ha;
  localparam logic [3:0]  BIT_ACK      = 4'h8;
  localparam logic [3:0]  BIT_END      = 4'h9;
  localparam logic [14:0] PTR_RST      = 15'h0000;
  localparam logic [14:0] PTR_TOP      = 15'h7fff;
  localparam logic [6:0]  COPY_LAST    = 7'h40;
  localparam int          PROG_TIME_US = 1000;
  localparam int          REF_CLK_MHZ  = 20;
  localparam int          PROG_CYCLES  = PROG_TIME_US * REF_CLK_MHZ;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_CTRL  = 6'h02,
    ST_AHI   = 6'h04,
    ST_ALO   = 6'h08,
    ST_WDATA = 6'h10,
    ST_RDATA = 6'h20
  } sepwr_state_e;

endpackage : sepwr_pkg

/* File: logic/sepwr_top.sv */
// Two-wire serial EEPROM slave: page writes, protect, polling and reads.
// Assumes link_clk runs freely and far faster than the serial clock pin.
`timescale 1ns/100ps
module sepwr_top
  import sepwr_pkg::*;
#(
  parameter int unsigned PROG_CYC = PROG_CYCLES
) (
  // Reference clock domain.
  input  logic            ref_clk,
  input  logic            sys_rst,
  // Link sampling clock.
  input  logic            link_clk,
  // Serial bus pins.
  input  logic            scl_i,
  input  logic            sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  // Strap and protect pins.
  input  logic [CS_W-1:0] chip_select_inputs,
  input  logic            write_protect,
  // Status.
  output logic            prog_busy
);

  if (PROG_CYC < 1) begin : g_bad_prog
    $error("sepwr_top needs a programming length of at least one cycle");
  end

  // Pin synchronisers and link-domain reset.
  logic [5:0]        pin_m_r;
  logic [5:0]        pin_s_r;
  logic              scl_d_r;
  logic              sda_d_r;
  logic              lrst_m_r;
  logic              link_rst_r;
  logic              done_m_r;
  logic              done_s_r;
  logic              done_d_r;
  logic              done_tgl;

  always_ff @(posedge link_clk) begin
    pin_m_r  <= {write_protect, chip_select_inputs, sda_i, scl_i};
    pin_s_r  <= pin_m_r;
    scl_d_r  <= pin_s_r[0];
    sda_d_r  <= pin_s_r[1];
    lrst_m_r <= sys_rst;
    link_rst_r <= lrst_m_r;
    done_m_r <= done_tgl;
    done_s_r <= done_m_r;
    done_d_r <= done_s_r;
  end

  wire              scl_s = pin_s_r[0];
  wire              sda_s = pin_s_r[1];
  wire [CS_W-1:0]   cs_s  = pin_s_r[4:2];
  wire              wp_s  = pin_s_r[5];
  wire              done_ev = done_s_r ^ done_d_r;

  // Link state.
  sepwr_state_e      st_r;
  sepwr_state_e      st_nxt;
  logic [3:0]        cnt_r;
  logic [7:0]        rx_r;
  logic [7:0]        tx_r;
  logic              sda_oe_r;
  logic              sda_oe_nxt;
  logic              match_r;
  logic              rw_r;
  logic              mack_r;
  logic [6:0]        hi_r;
  logic [ADDR_W-1:0] ptr_r;
  logic [ADDR_W-1:0] ptr_nxt;
  logic [63:0]       mask_r;
  logic              busy_r;
  logic              prog_tgl_r;
  logic [8:0]        page_r;
  logic              copying_r;
  logic [6:0]        cp_r;
  logic [7:0]        arr_q;
  logic [7:0]        buf_q;

  // Bus conditions and bit-slot events.
  wire scl_rise  = scl_s & ~scl_d_r;
  wire scl_fall  = ~scl_s & scl_d_r;
  wire bus_start = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire bus_stop  = scl_s & scl_d_r & ~sda_d_r & sda_s;
  wire ack_slot  = scl_fall & (cnt_r == BIT_ACK);
  wire byte_end  = scl_fall & (cnt_r == BIT_END);
  wire data_fall = scl_fall & (cnt_r != 4'h0) & (cnt_r < BIT_ACK);
  wire rd_shift  = data_fall & (st_r == ST_RDATA);

  wire addr_ok   = (rx_r[7:4] == CTRL_CODE) && (rx_r[3:1] == cs_s);
  // A busy device leaves the ack slot released, which is what a polling master watches for.
  wire ctrl_ack  = addr_ok & ~busy_r;
  wire rx_state  = (st_r == ST_AHI) | (st_r == ST_ALO) | (st_r == ST_WDATA);
  wire wr_byte   = byte_end & (st_r == ST_WDATA) & ~busy_r;
  wire rd_first  = (st_r == ST_CTRL) & match_r & rw_r;
  wire rd_next   = (st_r == ST_RDATA) & mack_r;
  wire rd_load   = byte_end & (rd_first | rd_next);
  wire wr_stop   = bus_stop & (st_r == ST_WDATA) & (|mask_r);
  wire prog_go   = wr_stop & ~wp_s;
  wire copy_end  = copying_r & (cp_r == COPY_LAST);

  // Copy from page buffer to array, one entry per cycle after the read latency.
  // Entries not written in this command leave the old array bytes in place.
  wire [5:0]  cp_idx   = 6'(cp_r - 7'h1);
  wire        arr_we   = copying_r & (cp_r != 7'h0) & mask_r[cp_idx];
  wire [14:0] arr_wa   = {page_r, cp_idx};
  wire        buf_we   = wr_byte;
  wire [5:0]  buf_wa   = ptr_r[PAGE_W-1:0];

  always_comb begin
    st_nxt = st_r;
    if (bus_start) begin
      st_nxt = ST_CTRL;
    end else if (bus_stop) begin
      st_nxt = ST_IDLE;
    end else if (byte_end) begin
      case (st_r)
        ST_CTRL:  st_nxt = !match_r ? ST_IDLE : (rw_r ? ST_RDATA : ST_AHI);
        ST_AHI:   st_nxt = ST_ALO;
        ST_ALO:   st_nxt = ST_WDATA;
        ST_WDATA: st_nxt = ST_WDATA;
        ST_RDATA: st_nxt = mack_r ? ST_RDATA : ST_IDLE;
        default:  st_nxt = ST_IDLE;
      endcase
    end
  end

  // The data line is only ever pulled low; a one is sent by releasing it.
  always_comb begin
    sda_oe_nxt = sda_oe_r;
    if (bus_start | bus_stop) begin
      sda_oe_nxt = 1'b0;
    end else if (ack_slot) begin
      sda_oe_nxt = ((st_r == ST_CTRL) & ctrl_ack) | rx_state;
    end else if (byte_end) begin
      sda_oe_nxt = rd_load & ~arr_q[7];
    end else if (rd_shift) begin
      sda_oe_nxt = ~tx_r[6];
    end
  end

  always_comb begin
    ptr_nxt = ptr_r;
    if (byte_end & (st_r == ST_ALO)) begin
      ptr_nxt = {hi_r, rx_r};
    end else if (wr_byte) begin
      ptr_nxt = {ptr_r[ADDR_W-1:PAGE_W], 6'(ptr_r[PAGE_W-1:0] + 6'h1)};
    end else if (rd_load) begin
      ptr_nxt = ptr_r + 15'h0001;
    end
  end

  always_ff @(posedge link_clk) begin
    if (link_rst_r) begin
      st_r     <= ST_IDLE;
      sda_oe_r <= 1'b0;
      ptr_r    <= PTR_RST;
    end else begin
      st_r     <= st_nxt;
      sda_oe_r <= sda_oe_nxt;
      ptr_r    <= ptr_nxt;
    end
  end

  always_ff @(posedge link_clk) begin
    if (link_rst_r | bus_start) begin
      cnt_r <= 4'h0;
    end else if (byte_end) begin
      cnt_r <= 4'h0;
    end else if (scl_rise & (cnt_r < BIT_END)) begin
      cnt_r <= cnt_r + 4'h1;
    end
  end

  always_ff @(posedge link_clk) begin
    if (link_rst_r) begin
      rx_r    <= 8'h00;
      tx_r    <= 8'h00;
      match_r <= 1'b0;
      rw_r    <= 1'b0;
      mack_r  <= 1'b0;
      hi_r    <= 7'h00;
    end else begin
      if (scl_rise & (cnt_r < BIT_ACK)) begin
        rx_r <= {rx_r[6:0], sda_s};
      end
      if (scl_rise & (cnt_r == BIT_ACK)) begin
        mack_r <= ~sda_s;
      end
      if (ack_slot & (st_r == ST_CTRL)) begin
        match_r <= ctrl_ack;
        rw_r    <= rx_r[0];
      end
      if (byte_end & (st_r == ST_AHI)) begin
        hi_r <= rx_r[6:0];
      end
      if (rd_load) begin
        tx_r <= arr_q;
      end else if (rd_shift) begin
        tx_r <= {tx_r[6:0], 1'b0};
      end
    end
  end

  // Programming: request, wait for the timer, then commit the buffered page.
  always_ff @(posedge link_clk) begin
    if (link_rst_r) begin
      busy_r     <= 1'b0;
      prog_tgl_r <= 1'b0;
      page_r     <= 9'h000;
      copying_r  <= 1'b0;
      cp_r       <= 7'h00;
      mask_r     <= 64'h0;
    end else begin
      if (prog_go) begin
        busy_r     <= 1'b1;
        prog_tgl_r <= ~prog_tgl_r;
        page_r     <= ptr_r[ADDR_W-1:PAGE_W];
      end
      if (done_ev & busy_r) begin
        copying_r <= 1'b1;
        cp_r      <= 7'h00;
      end else if (copy_end) begin
        copying_r <= 1'b0;
        busy_r    <= 1'b0;
      end else if (copying_r) begin
        cp_r <= cp_r + 7'h01;
      end
      if (copy_end | (wr_stop & wp_s) | (bus_start & ~busy_r)) begin
        mask_r <= 64'h0;
      end else if (buf_we) begin
        mask_r[buf_wa] <= 1'b1;
      end
    end
  end

  sepwr_mem #(.AW(ADDR_W), .DW(DATA_W)) u_array (
    .clk     (link_clk),
    .we      (arr_we),
    .waddr   (arr_wa),
    .wdata   (buf_q),
    .raddr   (ptr_r),
    .rdata_r (arr_q)
  );

  sepwr_mem #(.AW(PAGE_W), .DW(DATA_W)) u_page_buf (
    .clk     (link_clk),
    .we      (buf_we),
    .waddr   (buf_wa),
    .wdata   (rx_r),
    .raddr   (cp_r[PAGE_W-1:0]),
    .rdata_r (buf_q)
  );

  sepwr_wtimer #(.CYC(PROG_CYC)) u_timer (
    .ref_clk    (ref_clk),
    .sys_rst    (sys_rst),
    .req_tgl    (prog_tgl_r),
    .done_tgl_r (done_tgl),
    .busy_r     (prog_busy)
  );

  assign sda_o  = 1'b0;
  assign sda_oe = sda_oe_r;

  default clocking cb_link @(posedge link_clk); endclocking
  default disable iff (link_rst_r);

  a_busy_no_ack: assert property ((ack_slot && st_r == ST_CTRL && busy_r) |=> !sda_oe_r)
    else $error("Control byte acknowledged during programming.");
  a_ctrl_ack: assert property ((ack_slot && st_r == ST_CTRL && addr_ok && !busy_r) |=> sda_oe_r)
    else $error("Matching control byte not acknowledged.");
  a_page_incr: assert property (wr_byte |=>
    (ptr_r[14:6] == $past(ptr_r[14:6]) && ptr_r[5:0] == 6'($past(ptr_r[5:0]) + 6'h1)))
    else $error("Page write pointer stepped outside its page.");
  a_prot_idle: assert property ((wr_stop && wp_s && !busy_r) |=> (!busy_r && mask_r == 64'h0))
    else $error("Protected write started programming or kept data.");
  a_prog_start: assert property (prog_go |=> (busy_r && prog_tgl_r != $past(prog_tgl_r)))
    else $error("STOP of a write did not start programming.");
  a_read_incr: assert property (rd_load |=> ptr_r == 15'($past(ptr_r) + 15'h0001))
    else $error("Read did not advance the address counter.");
  a_read_wrap: assert property ((rd_load && ptr_r == PTR_TOP) |=> ptr_r == PTR_RST)
    else $error("Read pointer did not wrap to zero.");
  a_addr_load: assert property ((byte_end && st_r == ST_ALO) |=> ptr_r == {$past(hi_r), $past(rx_r)})
    else $error("Word address not loaded into the pointer.");
  a_idle_release: assert property (st_r == ST_IDLE |-> !sda_oe_r)
    else $error("Data line held while idle.");
  a_sel_refuse: assert property ((ack_slot && st_r == ST_CTRL && !addr_ok) |=> !sda_oe_r)
    else $error("Control byte for another device was acknowledged.");
  a_data_ack: assert property ((ack_slot && rx_state) |=> sda_oe_r)
    else $error("Address or data byte of a write not acknowledged.");
  a_nack_release: assert property ((byte_end && st_r == ST_RDATA && !mack_r) |=>
    (!sda_oe_r && st_r == ST_IDLE))
    else $error("Data line not released after the master refused a byte.");
  a_wp_no_prog: assert property ((wr_stop && wp_s) |=> prog_tgl_r == $past(prog_tgl_r))
    else $error("Protected write requested a programming cycle.");

  c_prog_go:   cover property (prog_go);
  c_poll_nack: cover property (ack_slot && st_r == ST_CTRL && addr_ok && busy_r);
  c_seq_read:  cover property (byte_end && rd_next);
  c_read_wrap: cover property (rd_load && ptr_r == PTR_TOP);
  c_prot_stop: cover property (wr_stop && wp_s);

endmodule : sepwr_top

/* File: logic/sepwr_wtimer.sv */
// Self-timed programming interval counted on the reference clock.
// Assumes req_tgl comes from the link domain; each flip is one start request.
`timescale 1ns/100ps
module sepwr_wtimer #(
  parameter int unsigned CYC = 20000
) (
  // Clock and reset.
  input  logic ref_clk,
  input  logic sys_rst,
  // Request from the link domain, answer back to it.
  input  logic req_tgl,
  output logic done_tgl_r,
  // Status.
  output logic busy_r
);

  localparam int CW = $clog2(CYC + 1);

  if (CYC < 1) begin : g_bad_cyc
    $error("sepwr_wtimer needs at least one cycle");
  end

  logic          req_m_r;
  logic          req_s_r;
  logic          req_d_r;
  logic [CW-1:0] cnt_r;
  wire           req_ev   = req_s_r ^ req_d_r;
  wire           cnt_zero = (cnt_r == '0);

  always_ff @(posedge ref_clk) begin
    req_m_r <= req_tgl;
    req_s_r <= req_m_r;
    req_d_r <= req_s_r;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      busy_r     <= 1'b0;
      cnt_r      <= '0;
      done_tgl_r <= 1'b0;
    end else if (busy_r) begin
      if (cnt_zero) begin
        busy_r     <= 1'b0;
        done_tgl_r <= ~done_tgl_r;
      end else begin
        cnt_r <= cnt_r - CW'(1);
      end
    end else if (req_ev) begin
      busy_r <= 1'b1;
      cnt_r  <= CW'(CYC - 1);
    end
  end

  a_timer_load: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (req_ev && !busy_r) |=> (busy_r && cnt_r == CW'(CYC - 1)))
    else $error("Programming counter not loaded with its full length.");
  a_timer_end: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (busy_r && cnt_zero) |=> (!busy_r && done_tgl_r != $past(done_tgl_r)))
    else $error("Programming interval did not end with a done event.");

endmodule : sepwr_wtimer

/* File: sim/sepwr_master.sv */
// Bus master model: drives the serial clock and pulls the data line low.
// Assumes the bench resolves the data line with a pull-up from both enables.
`timescale 1ns/100ps
module sepwr_master (
  // Clock.
  input  logic ref_clk,
  // Bus pins.
  output logic scl,
  output logic sda_low,
  input  logic sda_line
);
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  // A quarter bit is two reference cycles, well above the front end's settling.
  task automatic q_wait();
    repeat (2) @(negedge ref_clk);
  endtask : q_wait

  task automatic bit_io(input logic b, output logic s);
    q_wait();
    sda_low = ~b;
    q_wait();
    scl = 1'b1;
    q_wait();
    s = sda_line;
    q_wait();
    scl = 1'b0;
  endtask : bit_io

  task automatic start();
    q_wait();
    sda_low = 1'b0;
    q_wait();
    scl = 1'b1;
    q_wait();
    sda_low = 1'b1;
    q_wait();
    scl = 1'b0;
  endtask : start

  task automatic stop();
    q_wait();
    sda_low = 1'b1;
    q_wait();
    scl = 1'b1;
    q_wait();
    sda_low = 1'b0;
    q_wait();
  endtask : stop

  task automatic put_byte(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(v[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask : put_byte

  task automatic get_byte(input logic more, output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
    bit_io(~more, s);
  endtask : get_byte
endmodule : sepwr_master

/* File: sim/tb_serial_eeprom_page_write_read.sv */
// Testbench for the serial EEPROM slave: writes, protect, polling and reads.
// Assumes the master model in its own file and a pull-up on the data line.
`timescale 1ns/100ps
module tb_serial_eeprom_page_write_read;
  import sepwr_pkg::*;
  logic             ref_clk;
  logic             link_clk;
  logic             sys_rst;
  logic             write_protect;
  logic [CS_W-1:0]  cs;
  logic             sda_o;
  logic             sda_oe;
  logic             prog_busy;
  logic [14:0]      cur;
  logic [7:0]       exp_mem [logic [14:0]];
  wire              scl;
  wire              sda_low;
  wire              sda_line;
  int               bad_count;
  int               checks;

  assign sda_line = (sda_oe ? sda_o : 1'b1) & ~sda_low;

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial begin
    link_clk = 1'b0;
    #3.7;
    forever #7.5 link_clk = ~link_clk;
  end

  // Long enough that the first polls after a write are refused.
  sepwr_top #(.PROG_CYC(400)) u_dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .link_clk(link_clk), .scl_i(scl), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe(sda_oe), .chip_select_inputs(cs), .write_protect(write_protect),
    .prog_busy(prog_busy));
  sepwr_master u_mst (.ref_clk(ref_clk), .scl(scl), .sda_low(sda_low), .sda_line(sda_line));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tx(input logic [7:0] v, input logic exp_ack);
    logic ack;
    u_mst.put_byte(v, ack);
    chk({15'h0, ack}, {15'h0, exp_ack});
  endtask : tx

  task automatic set_addr(input logic [15:0] a);
    u_mst.start();
    tx({CTRL_CODE, cs, 1'b0}, 1'b1);
    tx(a[15:8], 1'b1);
    tx(a[7:0], 1'b1);
  endtask : set_addr

  task automatic wr(input logic [15:0] a, input int n, input logic [7:0] seed, input logic prot);
    logic [14:0] p;
    set_addr(a);
    p = a[14:0];
    for (int i = 0; i < n; i++) begin
      tx(seed + 8'(i), 1'b1);
      if (!prot) exp_mem[p] = seed + 8'(i);
      p[5:0] = p[5:0] + 6'h1;
    end
    u_mst.stop();
    cur = p;
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic rnd, input int n);
    logic [7:0] b;
    if (rnd) begin
      set_addr(a);
      cur = a[14:0];
    end
    u_mst.start();
    tx({CTRL_CODE, cs, 1'b1}, 1'b1);
    for (int i = 0; i < n; i++) begin
      u_mst.get_byte(i < n - 1, b);
      chk({8'h0, b}, {8'h0, exp_mem[cur]});
      cur = cur + 15'h1;
    end
    u_mst.stop();
    chk({15'h0, sda_oe}, 16'h0);
  endtask : rd

  task automatic poll(output int n);
    logic ack;
    n = 0;
    ack = 1'b0;
    while (!ack && n < 20) begin
      u_mst.start();
      u_mst.put_byte({CTRL_CODE, cs, 1'b0}, ack);
      if (!ack) n++;
    end
    u_mst.stop();
    chk({15'h0, ack}, 16'h1);
  endtask : poll

  task automatic s_page();
    int n;
    wr(16'h017c, 68, 8'h10, 1'b0);
    repeat (8) @(negedge ref_clk);
    chk({15'h0, prog_busy}, 16'h1);
    write_protect = 1'b1;
    poll(n);
    chk({15'h0, n != 0}, 16'h1);
    chk({15'h0, prog_busy}, 16'h0);
    write_protect = 1'b0;
    rd(16'h0140, 1'b1, 64);
  endtask : s_page

  task automatic s_protect();
    int n;
    write_protect = 1'b1;
    repeat (4) @(negedge ref_clk);
    wr(16'h0150, 4, 8'hc0, 1'b1);
    repeat (8) @(negedge ref_clk);
    chk({15'h0, prog_busy}, 16'h0);
    poll(n);
    chk(16'(n), 16'h0);
    write_protect = 1'b0;
    rd(16'h0150, 1'b1, 4);
  endtask : s_protect

  task automatic s_select();
    for (int i = 0; i < 2; i++) begin
      u_mst.start();
      tx(i == 0 ? {CTRL_CODE, cs ^ 3'h1, 1'b0} : {CTRL_CODE ^ 4'h1, cs, 1'b0}, 1'b0);
      u_mst.stop();
    end
    cs = 3'h2;
    repeat (4) @(negedge ref_clk);
  endtask : s_select

  task automatic s_roll();
    int n;
    wr(16'hffff, 1, 8'h5a, 1'b0);
    poll(n);
    chk({15'h0, n != 0}, 16'h1);
    wr(16'h0000, 1, 8'ha5, 1'b0);
    poll(n);
    rd(16'h7fff, 1'b1, 2);
  endtask : s_roll

  task automatic s_current();
    rd(16'h0140, 1'b1, 1);
    rd(16'h0000, 1'b0, 2);
  endtask : s_current

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (60000) @(posedge ref_clk);
    bad_count++;
    summarize();
  end

  initial begin
    sys_rst = 1'b1;
    write_protect = 1'b0;
    cs = 3'h5;
    cur = 15'h0;
    repeat (16) @(posedge ref_clk);
    @(negedge ref_clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    s_page();
    s_protect();
    s_select();
    s_roll();
    s_current();
    summarize();
  end
endmodule : tb_serial_eeprom_page_write_read
